// ==== shared/lfm_consts.svh ====
`ifndef LFM_CONSTS_SVH
`define LFM_CONSTS_SVH
// number of led channels
`define LFM_NCH        10
// fault status bit positions
`define LFM_F_INOC     0
`define LFM_F_UVP      1
`define LFM_F_TWARN    2
`define LFM_F_OTP      3
`define LFM_F_FREQ     4
`define LFM_F_SWLIM1   5
`define LFM_F_SWLIM2   6
`define LFM_F_OVP      7
`define LFM_F_DIODE    8
`define LFM_F_GSTART   9
`define LFM_F_GRUN     10
`define LFM_F_SSHORT   11
`define LFM_NFLT       12
// reset values
`define LFM_FLT_RST    12'h000
`define LFM_CH_RST     10'h000
// open/short test settle time in ns and clock period in ns
`define LFM_TEST_NS    1000
`define LFM_CLK_NS     10
`endif

// ==== shared/lfm_pkg.sv ====
package lfm_pkg;
  // fault detector inputs travelling together
  typedef struct packed {
    logic       in_oc;      // input sense node overcurrent
    logic       undervoltage_protect;        // undervoltage_protect
    logic       twarn;      // temperature warning
    logic       thermal_shutdown; // die above shutdown level
    logic       freq_pin_short;   // frequency_set_pin short
    logic       swlim1;     // primary switch limit
    logic       swlim2;     // secondary switch limit
    logic       overvoltage_protect;        // overvoltage_protect
    logic       ovp_hyst;   // output still above resume level
    logic       diode;      // secondary overvoltage at switch node
  } lfm_det_s;

  // supervisor states
  typedef enum logic [2:0] {
    LFM_IDLE   = 3'b000,
    LFM_CHECK  = 3'b001,
    LFM_RUN    = 3'b010,
    LFM_TEST   = 3'b011,
    LFM_LATCH  = 3'b100
  } lfm_state_e;
endpackage

// ==== hw/lfm_gpo.sv ====
`timescale 1ns/1ps
`include "lfm_consts.svh"
module lfm_gpo
  import lfm_pkg::*;
#(
  parameter int NFLT = `LFM_NFLT
)(
  input  wire logic            clock,   // system clock
  input  wire logic            rst_n,   // async reset
  input  wire logic [NFLT-1:0] status,  // live fault status
  input  wire logic [NFLT-1:0] sel,     // bits mirrored on pin
  output logic                 pin_o,   // pin output value (low)
  output logic                 pin_oe   // pin driven low when high
);
  logic hit_ff;

  // any selected status bit pulls the open-drain pin low
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      hit_ff <= 1'b0;
    else
      hit_ff <= |(status & sel);
  end

  assign pin_o  = 1'b0;
  assign pin_oe = hit_ff;
endmodule

// ==== hw/lfm_chan.sv ====
`timescale 1ns/1ps
`include "lfm_consts.svh"
module lfm_chan
  import lfm_pkg::*;
(
  input  wire logic clock,      // system clock
  input  wire logic rst_n,      // async reset
  input  wire logic clr,        // clears latched channel state
  input  wire logic enabled,    // channel enabled by user
  input  wire logic pwm_start,  // pulse at each pwm cycle start
  input  wire logic over_thr,   // pin above short-detect threshold
  input  wire logic auto_rst,   // string short auto restart
  input  wire logic mark_open,  // pulse: channel judged open
  output logic      short_ff,   // string short active
  output logic      open_ff,    // removed from regulation
  output logic      sink_ok     // sink may conduct
);
  // string short: drop at once, recheck at next pwm cycle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      short_ff <= 1'b0;
    else if (enabled && over_thr)
      short_ff <= 1'b1;
    else if (clr || (pwm_start && auto_rst))
      short_ff <= 1'b0;
  end

  // open channel stays out of regulation until cleared
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      open_ff <= 1'b0;
    else if (mark_open)
      open_ff <= 1'b1;
    else if (clr)
      open_ff <= 1'b0;
  end

  assign sink_ok = enabled && !short_ff && !open_ff && !over_thr;
endmodule

// ==== hw/lfm_top.sv ====
`timescale 1ns/1ps
`include "lfm_consts.svh"
// Notes on behaviour
// - input overcurrent latches everything off, flag low
// - undervoltage stops boost and sinks, programmable restart
// - temperature warning derates current, no flag
// - overtemperature stops boost, sinks; auto restart
// - frequency pin short stops boost and sinks, programmable restart
// - primary limit truncates present switch cycle only
// - secondary limit latches everything off
// - overvoltage regulated: stop boost, sinks stay, hysteresis
// - unregulated string tested: open dropped, short latches
// - open diode latches off, flag only while present
// - startup ground short withholds power-up, flags
// - string short drops channel, recheck next pwm
// - unreachable regulation at startup treated as open
// - programmable faults select latch or auto restart
// - twelve fault status bits readable
// - two open-drain outputs mirror selected status
module lfm_top
  import lfm_pkg::*;
#(
  parameter int NCH     = `LFM_NCH,
  parameter int NFLT    = `LFM_NFLT,
  parameter int TEST_CY = `LFM_TEST_NS / `LFM_CLK_NS
)(
  input  wire logic            clock,        // 100 MHz clock
  input  wire logic            rst_n,        // power-on reset, low
  input  wire logic            en,           // enable pin level
  input  wire lfm_det_s        det,          // fault detectors
  input  wire logic [NCH-1:0]  ch_en,        // channels enabled
  input  wire logic [NCH-1:0]  ch_reg,       // channel in regulation
  input  wire logic [NCH-1:0]  ch_gnd,       // pin below ground level
  input  wire logic [NCH-1:0]  ch_short,     // above short threshold
  input  wire logic            pwm_start,    // pwm cycle start pulse
  input  wire logic            softstart,    // startup ramp active
  input  wire logic [NFLT-1:0] latch_sel,    // 1 = latch, per fault
  input  wire logic [NFLT-1:0] sel_one,      // mirror on output one
  input  wire logic [NFLT-1:0] sel_two,      // mirror on output two
  output logic                 in_sw_en,     // input disconnect on
  output logic                 boost_en,     // boost may switch
  output logic                 boost_trunc,  // end present on-time
  output logic                 derate,       // reduce led current
  output logic [NCH-1:0]       sink_en,      // per-channel sink on
  output logic                 fault_n,      // fault output, low
  output logic [NFLT-1:0]      fault_sts,    // fault status bits
  output logic [NCH-1:0]       open_sts,     // channels found open
  output logic [NCH-1:0]       gnd_sts,      // channels shorted
  output logic                 status_output_one_o,  // pin value
  output logic                 status_output_one_oe, // pin driven
  output logic                 status_output_two_o,  // pin value
  output logic                 status_output_two_oe  // pin driven
);
  localparam logic [15:0] TEST_LEN = 16'(TEST_CY);
  // faults whose latch or restart behaviour cannot be programmed
  localparam logic [NFLT-1:0] FIX_LAT =
    NFLT'((1 << `LFM_F_INOC) | (1 << `LFM_F_SWLIM2) | (1 << `LFM_F_DIODE));
  localparam logic [NFLT-1:0] FIX_AUTO =
    NFLT'((1 << `LFM_F_TWARN) | (1 << `LFM_F_OTP) | (1 << `LFM_F_SWLIM1));

  lfm_state_e         state_ff;
  lfm_state_e         nxt_state;
  logic               en_ff;
  logic               clr;
  logic [NFLT-1:0]    sticky_ff;
  logic [NFLT-1:0]    live;
  logic [15:0]        tcnt_ff;
  logic [NCH-1:0]     short_v;
  logic [NCH-1:0]     open_v;
  logic [NCH-1:0]     ok_v;
  logic [NCH-1:0]     mark_open;
  logic [NCH-1:0]     gnd_ff;
  logic               ovp_hold_ff;
  logic               diode_ff;
  logic               lat_hard;
  logic               stop_boost;
  logic               stop_sink;
  logic               unreg;

  // enable rise clears latches
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      en_ff <= 1'b0;
    else
      en_ff <= en;
  end
  assign clr = en && !en_ff;

  // detector levels gathered into status positions
  always_comb
  begin
    live                 = `LFM_FLT_RST;
    live[`LFM_F_INOC]    = det.in_oc;
    live[`LFM_F_UVP]     = det.undervoltage_protect;
    live[`LFM_F_TWARN]   = det.twarn;
    live[`LFM_F_OTP]     = det.thermal_shutdown;
    live[`LFM_F_FREQ]    = det.freq_pin_short;
    live[`LFM_F_SWLIM1]  = det.swlim1;
    live[`LFM_F_SWLIM2]  = det.swlim2;
    live[`LFM_F_OVP]     = det.overvoltage_protect;
    live[`LFM_F_DIODE]   = det.diode;
    live[`LFM_F_GSTART]  = (state_ff == LFM_CHECK) && |(ch_gnd & ch_en);
    live[`LFM_F_GRUN]    = |gnd_ff;
    live[`LFM_F_SSHORT]  = |short_v;
  end

  // sticky flags: set wins over clear; non-latch faults follow level
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      sticky_ff <= `LFM_FLT_RST;
    else
      for (int i = 0; i < NFLT; i++)
        if (live[i])
          sticky_ff[i] <= 1'b1;
        else if (clr || FIX_AUTO[i] || (!latch_sel[i] && !FIX_LAT[i]))
          sticky_ff[i] <= 1'b0;
  end

  // faults that latch regardless of programming
  assign lat_hard = sticky_ff[`LFM_F_INOC] || sticky_ff[`LFM_F_SWLIM2]
                 || diode_ff || (|gnd_ff);

  // open diode latch separate: flag follows only the live condition
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      diode_ff <= 1'b0;
    else if (det.diode)
      diode_ff <= 1'b1;
    else if (clr)
      diode_ff <= 1'b0;
  end

  // overvoltage hold until output under resume level
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ovp_hold_ff <= 1'b0;
    else if (det.overvoltage_protect)
      ovp_hold_ff <= 1'b1;
    else if (!det.ovp_hyst)
      ovp_hold_ff <= 1'b0;
  end

  assign unreg = |(ch_en & ~ch_reg & ~open_v);

  // supervisor sequence
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      LFM_IDLE:  if (en) nxt_state = LFM_CHECK;
      LFM_CHECK: if (!live[`LFM_F_GSTART]) nxt_state = LFM_RUN;
      LFM_RUN:   if (det.overvoltage_protect && unreg) nxt_state = LFM_TEST;
      LFM_TEST:  if (tcnt_ff == TEST_LEN) nxt_state = LFM_RUN;
      LFM_LATCH: if (clr) nxt_state = LFM_CHECK;
      default:   nxt_state = LFM_IDLE;
    endcase
    if (state_ff != LFM_IDLE && !en && state_ff != LFM_LATCH)
      nxt_state = LFM_IDLE;
    if (lat_hard && state_ff != LFM_LATCH)
      nxt_state = LFM_LATCH;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= LFM_IDLE;
    else
      state_ff <= nxt_state;
  end

  // settle timer for the open/short test
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      tcnt_ff <= 16'h0000;
    else if (state_ff == LFM_TEST)
      tcnt_ff <= tcnt_ff + 16'h0001;
    else
      tcnt_ff <= 16'h0000;
  end

  // verdict at end of test: ground short latches, else open
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      gnd_ff <= `LFM_CH_RST;
    else if (state_ff == LFM_TEST && tcnt_ff == TEST_LEN)
      gnd_ff <= gnd_ff | (ch_en & ~ch_reg & ~open_v & ch_gnd);
    else if (clr)
      gnd_ff <= `LFM_CH_RST;
  end

  always_comb
  begin
    mark_open = `LFM_CH_RST;
    if (state_ff == LFM_TEST && tcnt_ff == TEST_LEN)
      mark_open = ch_en & ~ch_reg & ~ch_gnd;
    else if (softstart && det.overvoltage_protect)
      mark_open = ch_en & ~ch_reg & ~ch_gnd;
  end

  // per-channel short and open tracking
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    lfm_chan u_ch (
      .clock     (clock),
      .rst_n     (rst_n),
      .clr       (clr),
      .enabled   (ch_en[c]),
      .pwm_start (pwm_start),
      .over_thr  (ch_short[c]),
      .auto_rst  (!latch_sel[`LFM_F_SSHORT]),
      .mark_open (mark_open[c]),
      .short_ff  (short_v[c]),
      .open_ff   (open_v[c]),
      .sink_ok   (ok_v[c])
    );
  end

  // most restrictive action across active faults
  assign stop_boost = sticky_ff[`LFM_F_UVP] || det.thermal_shutdown
                   || sticky_ff[`LFM_F_FREQ] || ovp_hold_ff
                   || state_ff == LFM_TEST;
  assign stop_sink  = sticky_ff[`LFM_F_UVP] || det.thermal_shutdown
                   || sticky_ff[`LFM_F_FREQ];

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_sw_en <= 1'b0;
      boost_en <= 1'b0;
      sink_en  <= `LFM_CH_RST;
      derate   <= 1'b0;
      fault_n  <= 1'b1;
    end
    else
    begin
      in_sw_en <= en && !sticky_ff[`LFM_F_INOC]
               && !sticky_ff[`LFM_F_SWLIM2] && !diode_ff;
      boost_en <= state_ff == LFM_RUN && !stop_boost && !lat_hard;
      sink_en  <= (state_ff == LFM_RUN || state_ff == LFM_TEST)
               && !stop_sink && !lat_hard ? ok_v : `LFM_CH_RST;
      derate   <= det.twarn;
      fault_n  <= !(sticky_ff[`LFM_F_INOC] || sticky_ff[`LFM_F_UVP]
               || det.thermal_shutdown || sticky_ff[`LFM_F_FREQ]
               || sticky_ff[`LFM_F_SWLIM2] || ovp_hold_ff
               || det.diode || live[`LFM_F_GSTART]
               || (|gnd_ff) || sticky_ff[`LFM_F_SSHORT]);
    end
  end

  assign boost_trunc = det.swlim1;
  assign fault_sts   = sticky_ff;
  assign open_sts    = open_v;
  assign gnd_sts     = gnd_ff;

  lfm_gpo u_status_output_one (
    .clock  (clock),
    .rst_n  (rst_n),
    .status (sticky_ff),
    .sel    (sel_one),
    .pin_o  (status_output_one_o),
    .pin_oe (status_output_one_oe)
  );

  lfm_gpo u_status_output_two (
    .clock  (clock),
    .rst_n  (rst_n),
    .status (sticky_ff),
    .sel    (sel_two),
    .pin_o  (status_output_two_o),
    .pin_oe (status_output_two_oe)
  );

  sequence s_oc;
    det.in_oc;
  endsequence
  sequence s_off;
    !in_sw_en && !boost_en && !fault_n;
  endsequence

  inoc_latch_a: assert property (@(posedge clock) disable iff (!rst_n)
    s_oc |-> ##2 s_off) else $error("overcurrent not latched off");
  swlim2_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    det.swlim2 |-> ##2 (!in_sw_en && sink_en == '0))
    else $error("secondary limit not off");
  twarn_nf_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(derate) |-> $past(det.twarn))
    else $error("derate without warning");
  heat_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
    det.thermal_shutdown |=> (!boost_en && sink_en == '0))
    else $error("thermal stop missed");
  trunc_pass_a: assert property (@(posedge clock) disable iff (!rst_n)
    boost_trunc == det.swlim1) else $error("truncate wrong");
  ovp_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    det.overvoltage_protect |-> ##2 !boost_en) else $error("boost ran in overvoltage");
  latch_stay_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state_ff == LFM_LATCH && !clr) |=> state_ff == LFM_LATCH)
    else $error("latch left without enable rise");
  status_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    det.undervoltage_protect |=> fault_sts[`LFM_F_UVP])
    else $error("status bit not set");
  check_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state_ff == LFM_CHECK && live[`LFM_F_GSTART] && !lat_hard && en)
    |=> state_ff == LFM_CHECK) else $error("startup short ignored");
endmodule

// ==== test/lfm_plant.sv ====
`timescale 1ns/1ps
module lfm_plant
#(
  parameter int NCH    = 10,
  parameter int PWM_CY = 16
)(
  input  wire logic           clock,     // system clock
  input  wire logic           rst_n,     // async reset
  input  wire logic [NCH-1:0] ch_en,     // channels enabled
  input  wire logic [NCH-1:0] broken,    // strings with no current path
  input  wire logic           boost_en,  // boost switching allowed
  output logic [NCH-1:0]      ch_reg,    // string in regulation
  output logic                pwm_start, // pwm cycle start pulse
  output logic                softstart  // startup ramp active
);
  logic [7:0] pwm_cnt_ff;
  logic [3:0] ramp_ff;
  logic       boost_q_ff;

  // a string with no current path never reaches regulation
  assign ch_reg = ch_en & ~broken;

  // free running pwm period, start pulse lasts one cycle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pwm_cnt_ff <= 8'h00;
    else if (pwm_cnt_ff == 8'(PWM_CY - 1))
      pwm_cnt_ff <= 8'h00;
    else
      pwm_cnt_ff <= pwm_cnt_ff + 8'h01;
  end
  assign pwm_start = rst_n & (pwm_cnt_ff == 8'h00);

  // ramp flag for a few cycles after boost begins switching
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ramp_ff    <= 4'h0;
      boost_q_ff <= 1'b0;
    end
    else
    begin
      boost_q_ff <= boost_en;
      if (boost_en & ~boost_q_ff)
        ramp_ff <= 4'h8;
      else if (ramp_ff != 4'h0)
        ramp_ff <= ramp_ff - 4'h1;
    end
  end
  assign softstart = (ramp_ff != 4'h0);
endmodule

// ==== test/lfm_top_tb_top.sv ====
`timescale 1ns/1ps
`include "lfm_consts.svh"
module lfm_top_tb_top;
  import lfm_pkg::*;
  localparam int PWM = 16;
  localparam logic [9:0] CH = 10'h2ff;
  localparam logic [9:0] D_INOC = 10'h200, D_UVP = 10'h100;
  localparam logic [9:0] D_TW = 10'h080, D_HOT = 10'h040;
  localparam logic [9:0] D_FRQ = 10'h020, D_SW1 = 10'h010;
  localparam logic [9:0] D_SW2 = 10'h008, D_OVP = 10'h004;
  localparam logic [9:0] D_HYS = 10'h002, D_DIO = 10'h001;
  logic        clock, rst_n, en, pwm_start, softstart;
  lfm_det_s    det;
  logic [9:0]  ch_en, ch_reg, ch_gnd, ch_short, broken, sink_en;
  logic [9:0]  open_sts, gnd_sts;
  logic [11:0] latch_sel, sel_one, sel_two, fault_sts;
  logic        in_sw_en, boost_en, boost_trunc, derate, fault_n;
  logic        one_oe, two_oe, one_o, two_o;
  int          n_mismatch, num_checks;

  // dut with a short open/short test window
  lfm_top #(.TEST_CY(4)) lfm_top_inst (
    .clock(clock), .rst_n(rst_n), .en(en), .det(det), .ch_en(ch_en),
    .ch_reg(ch_reg), .ch_gnd(ch_gnd), .ch_short(ch_short),
    .pwm_start(pwm_start), .softstart(softstart),
    .latch_sel(latch_sel), .sel_one(sel_one), .sel_two(sel_two),
    .in_sw_en(in_sw_en), .boost_en(boost_en), .boost_trunc(boost_trunc),
    .derate(derate), .sink_en(sink_en), .fault_n(fault_n),
    .fault_sts(fault_sts), .open_sts(open_sts), .gnd_sts(gnd_sts),
    .status_output_one_o(one_o), .status_output_one_oe(one_oe),
    .status_output_two_o(two_o), .status_output_two_oe(two_oe));

  // power stage and led strings
  lfm_plant #(.PWM_CY(PWM)) lfm_plant_inst (
    .clock(clock), .rst_n(rst_n), .ch_en(ch_en), .broken(broken),
    .boost_en(boost_en), .ch_reg(ch_reg), .pwm_start(pwm_start),
    .softstart(softstart));

  // 100 mhz clock
  always #5 clock = ~clock;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // compare power outputs once the edge's updates have landed
  task automatic outs(input logic sw, bo, fn, input logic [9:0] sk);
    #1;
    check({in_sw_en, boost_en, fault_n}, {sw, bo, fn});
    check(sink_en, sk);
  endtask

  // drive the detectors, then let n edges pass
  task automatic drv(input logic [9:0] v, input int n);
    @(posedge clock) det <= lfm_det_s'(v);
    repeat (n) @(posedge clock);
  endtask

  // enable low then high clears latched state
  task automatic restart();
    @(posedge clock) en <= 1'b0;
    repeat (2) @(posedge clock);
    en <= 1'b1;
    repeat (6) @(posedge clock);
  endtask

  task automatic test_done();
    if (n_mismatch == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // cut a hang short
  initial
  begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    test_done();
  end

  initial
  begin
    logic [9:0] am [3];
    int         ab [3];
    am = '{D_UVP, D_HOT, D_FRQ};
    ab = '{`LFM_F_UVP, `LFM_F_OTP, `LFM_F_FREQ};
    clock = 1'b0;
    rst_n = 1'b0;
    en = 1'b0;
    det = '0;
    ch_en = CH;
    ch_gnd = '0;
    ch_short = '0;
    broken = '0;
    latch_sel = '0;
    sel_one = 12'h001;
    sel_two = 12'h080;
    n_mismatch = 0;
    num_checks = 0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    outs(1'b0, 1'b0, 1'b1, 10'h000);
    check({one_o, two_o, one_oe, two_oe, fault_sts}, 16'h0000);
    restart();
    outs(1'b1, 1'b1, 1'b1, CH);
    // latched faults from a one-cycle detector pulse
    for (int i = 0; i < 2; i++)
    begin
      drv(i == 0 ? D_INOC : D_SW2, 0);
      drv(10'h000, 4);
      outs(1'b0, 1'b0, 1'b0, 10'h000);
      check(fault_sts[i == 0 ? `LFM_F_INOC : `LFM_F_SWLIM2], 1'b1);
      check({one_o, one_oe}, {1'b0, i == 0});
      restart();
      outs(1'b1, 1'b1, 1'b1, CH);
    end
    // open diode: flag only while it persists
    drv(D_DIO, 4);
    outs(1'b0, 1'b0, 1'b0, 10'h000);
    drv(10'h000, 4);
    outs(1'b0, 1'b0, 1'b1, 10'h000);
    restart();
    // auto restart faults, overtemperature ignores latch select
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clock) latch_sel <= (i == 1) ? 12'hfff : 12'h000;
      drv(am[i], 4);
      outs(1'b1, 1'b0, 1'b0, 10'h000);
      check(fault_sts[ab[i]], 1'b1);
      drv(10'h000, 6);
      outs(1'b1, 1'b1, 1'b1, CH);
    end
    // undervoltage set to latch stays off after it clears
    @(posedge clock) latch_sel <= 12'h002;
    drv(D_UVP, 4);
    drv(10'h000, 6);
    outs(1'b1, 1'b0, 1'b0, 10'h000);
    @(posedge clock) latch_sel <= 12'h000;
    restart();
    // temperature warning derates only
    drv(D_TW, 4);
    outs(1'b1, 1'b1, 1'b1, CH);
    check({derate, fault_sts[`LFM_F_TWARN]}, 2'b11);
    drv(10'h000, 4);
    #1 check({derate, fault_sts[`LFM_F_TWARN]}, 2'b00);
    // primary limit truncates in the same cycle
    @(posedge clock) det <= lfm_det_s'(D_SW1);
    #1 check(boost_trunc, 1'b1);
    drv(D_SW1, 3);
    outs(1'b1, 1'b1, 1'b1, CH);
    check(fault_sts[`LFM_F_SWLIM1], 1'b1);
    // overvoltage with all strings regulated, hysteresis on resume
    drv(D_OVP | D_HYS, 4);
    outs(1'b1, 1'b0, 1'b0, CH);
    check(two_oe, 1'b1);
    drv(D_HYS, 4);
    #1 check(boost_en, 1'b0);
    drv(10'h000, 6);
    outs(1'b1, 1'b1, 1'b1, CH);
    // undervoltage overrides the sinks that overvoltage keeps on
    drv(D_UVP | D_OVP | D_HYS | D_TW, 4);
    outs(1'b1, 1'b0, 1'b0, 10'h000);
    check(derate, 1'b1);
    drv(10'h000, 8);
    restart();
    // unregulated open string dropped, others continue
    broken <= 10'h008;
    drv(D_OVP | D_HYS, 10);
    #1 check(open_sts, 10'h008);
    drv(10'h000, 6);
    outs(1'b1, 1'b1, 1'b1, CH & ~10'h008);
    @(posedge clock) broken <= 10'h000;
    restart();
    #1 check(open_sts, 10'h000);
    // unregulated string shorted to ground latches off
    @(posedge clock) broken <= 10'h020;
    ch_gnd <= 10'h020;
    drv(D_OVP | D_HYS, 10);
    drv(10'h000, 6);
    outs(1'b1, 1'b0, 1'b0, 10'h000);
    check({gnd_sts, fault_sts[`LFM_F_GRUN]}, {10'h020, 1'b1});
    // ground short found at power-up withholds start
    @(posedge clock) broken <= 10'h000;
    ch_gnd <= 10'h001;
    restart();
    outs(1'b1, 1'b0, 1'b0, 10'h000);
    check(fault_sts[`LFM_F_GSTART], 1'b1);
    @(posedge clock) ch_gnd <= 10'h000;
    repeat (6) @(posedge clock);
    outs(1'b1, 1'b1, 1'b1, CH);
    // string short, with and without restart at the next pwm cycle
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clock) latch_sel <= (i == 0) ? 12'h000 : 12'h800;
      ch_short <= 10'h002;
      repeat (3) @(posedge clock);
      outs(1'b1, 1'b1, 1'b0, CH & ~10'h002);
      check(fault_sts[`LFM_F_SSHORT], 1'b1);
      @(posedge clock) ch_short <= 10'h000;
      repeat (PWM + 4) @(posedge clock);
      #1 check(sink_en, i == 0 ? CH : CH & ~10'h002);
    end
    test_done();
  end
endmodule
